/* common/pcsia_map.svh */
// Offsets, field positions, reset values and counts for the program-flow block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PCSIA_MAP_SVH
`define PCSIA_MAP_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define PCSIA_PC_W 13
`define PCSIA_DATA_W 8
`define PCSIA_ADDR_W 9
`define PCSIA_JUMP_W 11
`define PCSIA_LATCH_W 5
`define PCSIA_STACK_DEPTH 8
`define PCSIA_STACK_PTR_W 3

// ****************************************************************
// Register offsets (low seven address bits, mirrored in every bank)
// ****************************************************************
`define PCSIA_OFS_IND_PORT 7'h00
`define PCSIA_OFS_PC_LOW 7'h02
`define PCSIA_OFS_BANK 7'h03
`define PCSIA_OFS_POINTER 7'h04
`define PCSIA_OFS_PC_LATCH 7'h0A
`define PCSIA_OFS_RESET_CAUSE 7'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define PCSIA_BANK_BIT 7
`define PCSIA_RC_OSC_BIT 3
`define PCSIA_RC_POR_BIT 1
`define PCSIA_RC_BOR_BIT 0
`define PCSIA_LATCH_TOP_HI 4
`define PCSIA_LATCH_TOP_LO 3

// ****************************************************************
// Reset values and vectors
// ****************************************************************
`define PCSIA_PC_RESET 13'h0000
`define PCSIA_IRQ_VECTOR 13'h0004
`define PCSIA_OSC_RESET 1'b1
`define PCSIA_BRANCH_CYCLES 2

`endif

/* common/pcsia_pkg.sv */
// Types shared by the program-flow block and its return stack.
// Assumes pcsia_map.svh is on the include path.
`include "pcsia_map.svh"

package pcsia_pkg;

	typedef logic [`PCSIA_PC_W-1:0] pcsia_pc_t;
	typedef logic [`PCSIA_DATA_W-1:0] pcsia_byte_t;
	typedef logic [`PCSIA_ADDR_W-1:0] pcsia_addr_t;

	// Gray coded along run -> flush -> run
	typedef enum logic [1:0] {
		PCSIA_PIPE_RUN = 2'b00,
		PCSIA_PIPE_FLUSH = 2'b01
	} pcsia_pipe_e;

endpackage

/* common/pcsia_stack_if.sv */
// Carrier between the program counter logic and the return stack.
// Assumes both ends share one clock and clock enable.
`timescale 1ns/1ps

interface pcsia_stack_if;
	import pcsia_pkg::*;

	logic push;
	logic pop;
	pcsia_pc_t push_data;
	pcsia_pc_t top_data;

	modport core (output push, output pop, output push_data, input top_data);
	modport stack (input push, input pop, input push_data, output top_data);

endinterface

/* design/pcsia_stack.sv */
// Eight-entry circular return stack with a hidden pointer.
// Assumes the core never asks for push and pop in the same cycle.
`timescale 1ns/1ps
`include "pcsia_map.svh"

module pcsia_stack #(
	parameter int DEPTH = `PCSIA_STACK_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	// Core side
	pcsia_stack_if.stack stk
);
	import pcsia_pkg::*;

	localparam int PW = $clog2(DEPTH);

	pcsia_pc_t entry [DEPTH];
	pcsia_pc_t next_entry [DEPTH];
	logic [PW-1:0] ptr;
	logic [PW-1:0] next_ptr;

	// ****************************************************************
	// Pointer
	// ****************************************************************
	// Wrapping is silent: no overflow or underflow flag exists
	always_comb begin
		next_ptr = ptr;
		if (stk.push) begin
			next_ptr = PW'(ptr + 1'b1);
		end else if (stk.pop) begin
			next_ptr = PW'(ptr - 1'b1);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ptr <= '0;
		end else if (clk_en) begin
			ptr <= next_ptr;
		end
	end

	// ****************************************************************
	// Entries
	// ****************************************************************
	// A push past the eighth lands on the oldest entry
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_comb begin
			next_entry[i] = entry[i];
			if (stk.push && ptr == PW'(i)) begin
				next_entry[i] = stk.push_data;
			end
		end

		always_ff @(posedge clock) begin
			if (clk_en) begin
				entry[i] <= next_entry[i];
			end
		end
	end

	assign stk.top_data = entry[PW'(ptr - 1'b1)];

	stack_wrap_a: assert property (@(posedge clock) disable iff (srst)
		clk_en && stk.push |=> entry[$past(ptr)] == $past(stk.push_data))
		else $error("push did not land at the wrapping pointer");

endmodule // pcsia_stack

/* design/pcsia_core.sv */
// Program counter, return stack control, indirect addressing and reset cause register.
// Assumes a decoder that raises at most one flow request per cycle and a data
// memory with a combinational read port.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "pcsia_map.svh"

module pcsia_core #(
	parameter logic [`PCSIA_PC_W-1:0] IRQ_VECTOR = `PCSIA_IRQ_VECTOR
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	// Reset cause, sampled while srst is high
	input wire logic rst_by_power_on,
	input wire logic rst_by_brownout,
	input wire logic brownout_enable_fuse,
	// Oscillator control
	input wire logic external_resistor_mode,
	output logic osc_speed_select,
	output logic osc_use_resistor,
	// Instruction flow from the decoder
	input wire logic pc_step,
	input wire logic op_call,
	input wire logic op_jump,
	input wire logic op_return,
	input wire logic op_return_with_literal,
	input wire logic op_return_from_interrupt,
	input wire logic irq_branch,
	input wire logic [`PCSIA_JUMP_W-1:0] jump_operand,
	output pcsia_pkg::pcsia_pc_t fetch_pc,
	output logic fetch_discard,
	// Register port
	input wire logic [`PCSIA_ADDR_W-1:0] reg_addr,
	input wire logic [`PCSIA_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output pcsia_pkg::pcsia_byte_t reg_rdata,
	// Data memory
	output pcsia_pkg::pcsia_addr_t dm_addr,
	output pcsia_pkg::pcsia_byte_t dm_wdata,
	output logic dm_we,
	output logic dm_re,
	input wire logic [`PCSIA_DATA_W-1:0] dm_rdata
);
	import pcsia_pkg::*;

	pcsia_stack_if stk ();

	pcsia_stack #(
		.DEPTH(`PCSIA_STACK_DEPTH)
	) u_stack (
		.clock(clock),
		.srst(srst),
		.clk_en(clk_en),
		.stk(stk.stack)
	);

	// ****************************************************************
	// Address decode
	// ****************************************************************
	pcsia_pc_t pc;
	pcsia_pc_t next_pc;
	logic [`PCSIA_LATCH_W-1:0] pc_high_latch;
	logic [`PCSIA_LATCH_W-1:0] next_pc_high_latch;
	pcsia_byte_t pointer_register;
	pcsia_byte_t next_pointer_register;
	logic indirect_bank_high_bit;
	logic next_indirect_bank_high_bit;
	logic por_flag;
	logic next_por_flag;
	logic brownout_flag;
	logic next_brownout_flag;
	logic next_osc_speed_select;
	pcsia_byte_t next_reg_rdata;
	pcsia_pipe_e pipe;
	pcsia_pipe_e next_pipe;

	logic is_indirect;
	pcsia_addr_t eff_addr;
	pcsia_addr_t tgt_addr;
	logic [6:0] tgt_ofs;
	logic tgt_self;
	logic tgt_pc_low;
	logic tgt_bank;
	logic tgt_pointer;
	logic tgt_latch;
	logic tgt_cause;
	logic tgt_ext;
	logic wr_pc_low;
	logic any_return;
	logic branch;
	pcsia_byte_t cause_view;

	// Bank bit on top of the pointer forms the nine-bit address
	assign eff_addr = {indirect_bank_high_bit, pointer_register};
	// The indirect port has no storage; it redirects to the pointer target
	assign is_indirect = reg_addr[6:0] == `PCSIA_OFS_IND_PORT;
	assign tgt_addr = is_indirect ? eff_addr : reg_addr;
	assign tgt_ofs = tgt_addr[6:0];

	always_comb begin
		tgt_self = 1'b0;
		tgt_pc_low = 1'b0;
		tgt_bank = 1'b0;
		tgt_pointer = 1'b0;
		tgt_latch = 1'b0;
		tgt_cause = 1'b0;
		tgt_ext = 1'b0;
		case (tgt_ofs)
			`PCSIA_OFS_IND_PORT: tgt_self = 1'b1;
			`PCSIA_OFS_PC_LOW: tgt_pc_low = 1'b1;
			`PCSIA_OFS_BANK: tgt_bank = 1'b1;
			`PCSIA_OFS_POINTER: tgt_pointer = 1'b1;
			`PCSIA_OFS_PC_LATCH: tgt_latch = 1'b1;
			`PCSIA_OFS_RESET_CAUSE: tgt_cause = 1'b1;
			default: tgt_ext = 1'b1;
		endcase
	end

	// ****************************************************************
	// Data memory port
	// ****************************************************************
	// A self-selecting indirect write reaches nothing
	assign dm_addr = tgt_addr;
	assign dm_wdata = reg_wdata;
	assign dm_we = clk_en && reg_wr && tgt_ext;
	assign dm_re = clk_en && reg_rd && tgt_ext;

	// ****************************************************************
	// Reset cause and oscillator speed
	// ****************************************************************
	// Unimplemented bits stay zero
	always_comb begin
		cause_view = '0;
		cause_view[`PCSIA_RC_OSC_BIT] = osc_speed_select;
		cause_view[`PCSIA_RC_POR_BIT] = por_flag;
		cause_view[`PCSIA_RC_BOR_BIT] = brownout_flag;
	end

	always_comb begin
		next_osc_speed_select = osc_speed_select;
		next_por_flag = por_flag;
		next_brownout_flag = brownout_flag;
		if (srst) begin
			next_osc_speed_select = `PCSIA_OSC_RESET;
			// Power-on shows zero, every other reset shows one
			next_por_flag = !rst_by_power_on;
			// Power-on leaves the brown-out flag meaningless; zero is our pick
			if (rst_by_power_on || (rst_by_brownout && brownout_enable_fuse)) begin
				next_brownout_flag = 1'b0;
			end
		end else if (reg_wr && tgt_cause) begin
			next_osc_speed_select = reg_wdata[`PCSIA_RC_OSC_BIT];
			// Software re-arms both flags so a later reset can be told apart
			next_por_flag = reg_wdata[`PCSIA_RC_POR_BIT];
			next_brownout_flag = reg_wdata[`PCSIA_RC_BOR_BIT];
		end
	end

	// Cause inputs are taken even with the clock enable low, so no reset is missed
	always_ff @(posedge clock) begin
		if (srst || clk_en) begin
			osc_speed_select <= next_osc_speed_select;
			por_flag <= next_por_flag;
			brownout_flag <= next_brownout_flag;
		end
	end

	// In resistor mode the fast setting hands the rate to the external resistor
	assign osc_use_resistor = external_resistor_mode && osc_speed_select;

	// ****************************************************************
	// Software visible registers
	// ****************************************************************
	always_comb begin
		next_pc_high_latch = pc_high_latch;
		next_pointer_register = pointer_register;
		next_indirect_bank_high_bit = indirect_bank_high_bit;
		if (reg_wr && tgt_latch) begin
			next_pc_high_latch = reg_wdata[`PCSIA_LATCH_W-1:0];
		end
		if (reg_wr && tgt_pointer) begin
			next_pointer_register = reg_wdata;
		end
		if (reg_wr && tgt_bank) begin
			next_indirect_bank_high_bit = reg_wdata[`PCSIA_BANK_BIT];
		end
	end

	// Read data stand only in the cycle after the strobe
	always_comb begin
		next_reg_rdata = '0;
		if (reg_rd) begin
			if (tgt_self) begin
				next_reg_rdata = '0;
			end else if (tgt_pc_low) begin
				next_reg_rdata = pc[7:0];
			end else if (tgt_latch) begin
				next_reg_rdata = {3'h0, pc_high_latch};
			end else if (tgt_pointer) begin
				next_reg_rdata = pointer_register;
			end else if (tgt_bank) begin
				next_reg_rdata = {indirect_bank_high_bit, 7'h00};
			end else if (tgt_cause) begin
				next_reg_rdata = cause_view;
			end else begin
				next_reg_rdata = dm_rdata;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			pc_high_latch <= '0;
			pointer_register <= '0;
			indirect_bank_high_bit <= 1'b0;
			reg_rdata <= '0;
		end else if (clk_en) begin
			pc_high_latch <= next_pc_high_latch;
			pointer_register <= next_pointer_register;
			indirect_bank_high_bit <= next_indirect_bank_high_bit;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ****************************************************************
	// Program counter and stack control
	// ****************************************************************
	assign any_return = op_return || op_return_with_literal || op_return_from_interrupt;
	assign wr_pc_low = reg_wr && tgt_pc_low;
	assign branch = irq_branch || any_return || op_call || op_jump || wr_pc_low;

	// Stack actions never touch the latch
	assign stk.push = clk_en && !srst && (irq_branch || (op_call && !any_return));
	assign stk.pop = clk_en && !srst && !irq_branch && any_return;
	assign stk.push_data = pc;

	// Low byte writes and calls or jumps take the upper bits from the latch, never from the data bus
	always_comb begin
		next_pc = pc;
		if (irq_branch) begin
			next_pc = IRQ_VECTOR;
		end else if (any_return) begin
			next_pc = stk.top_data;
		end else if (op_call || op_jump) begin
			next_pc = {pc_high_latch[`PCSIA_LATCH_TOP_HI:`PCSIA_LATCH_TOP_LO], jump_operand};
		end else if (wr_pc_low) begin
			next_pc = {pc_high_latch, reg_wdata};
		end else if (pc_step) begin
			next_pc = `PCSIA_PC_W'(pc + 1'b1);
		end
	end

	// A branch discards the instruction already fetched, costing one more cycle
	always_comb begin
		next_pipe = PCSIA_PIPE_RUN;
		case (pipe)
			PCSIA_PIPE_RUN: next_pipe = branch ? PCSIA_PIPE_FLUSH : PCSIA_PIPE_RUN;
			PCSIA_PIPE_FLUSH: next_pipe = branch ? PCSIA_PIPE_FLUSH : PCSIA_PIPE_RUN;
			default: next_pipe = PCSIA_PIPE_RUN;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			pc <= `PCSIA_PC_RESET;
			pipe <= PCSIA_PIPE_RUN;
		end else if (clk_en) begin
			pc <= next_pc;
			pipe <= next_pipe;
		end
	end

	assign fetch_pc = pc;
	assign fetch_discard = pipe == PCSIA_PIPE_FLUSH;

	// ****************************************************************
	// Checks
	// ****************************************************************
	pc_reset_a: assert property (@(posedge clock)
		srst |=> pc == '0 && !fetch_discard)
		else $error("program counter not cleared by reset");

	pcl_write_a: assert property (@(posedge clock) disable iff (srst)
		clk_en && wr_pc_low && !irq_branch && !any_return && !op_call && !op_jump
		|=> pc == {$past(pc_high_latch), $past(reg_wdata)})
		else $error("low byte write did not load latch bits");

	jump_load_a: assert property (@(posedge clock) disable iff (srst)
		clk_en && (op_call || op_jump) && !irq_branch && !any_return
		|=> pc[12:11] == $past(pc_high_latch[4:3]) && pc[10:0] == $past(jump_operand))
		else $error("call or jump target mis-formed");

	call_return_a: assert property (@(posedge clock) disable iff (srst)
		clk_en && op_call && !irq_branch && !any_return ##1
		(clk_en && op_return && !irq_branch)[*1]
		|=> pc == $past(pc, 2))
		else $error("return did not restore the pushed address");

	latch_keep_a: assert property (@(posedge clock) disable iff (srst)
		clk_en && (stk.push || stk.pop) && !(reg_wr && tgt_latch)
		|=> $stable(pc_high_latch))
		else $error("stack action changed the high latch");

	self_read_a: assert property (@(posedge clock) disable iff (srst)
		clk_en && reg_rd && is_indirect && eff_addr[6:0] == `PCSIA_OFS_IND_PORT
		|=> reg_rdata == 8'h00)
		else $error("indirect self read not zero");

	self_write_a: assert property (@(posedge clock) disable iff (srst)
		reg_wr && is_indirect && eff_addr[6:0] == `PCSIA_OFS_IND_PORT |-> !dm_we)
		else $error("indirect self write reached memory");

	eff_addr_a: assert property (@(posedge clock) disable iff (srst)
		clk_en && is_indirect && tgt_ext && (reg_rd || reg_wr)
		|-> dm_addr == {indirect_bank_high_bit, pointer_register})
		else $error("indirect address not bank bit over pointer");

	cause_zero_a: assert property (@(posedge clock) disable iff (srst)
		clk_en && reg_rd && !is_indirect && tgt_cause |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[2])
		else $error("unimplemented cause bits read non-zero");

	osc_reset_a: assert property (@(posedge clock)
		srst |=> osc_speed_select)
		else $error("speed select not one after reset");

	por_flag_a: assert property (@(posedge clock)
		srst |=> por_flag == !$past(rst_by_power_on))
		else $error("power-on flag wrong after reset");

	branch_cost_a: assert property (@(posedge clock) disable iff (srst)
		clk_en && branch |=> fetch_discard)
		else $error("branch did not cost a second cycle");

endmodule // pcsia_core

/* sim/pcsia_dmem_model.sv */
// Data memory model standing behind the block's data port.
// Assumes one clock; reads are combinational, writes land at the rising edge.
`timescale 1ns/1ps

module pcsia_dmem_model (
	// Clock
	input wire logic clock,
	// Data port
	input wire logic [8:0] dm_addr,
	input wire logic [7:0] dm_wdata,
	input wire logic dm_we,
	input wire logic dm_re,
	output logic [7:0] dm_rdata
);
	logic [7:0] mem [512];
	logic [7:0] junk = 8'hA5;

	initial begin
		for (int i = 0; i < 512; i++) begin
			mem[i] = 8'h00;
		end
	end

	// Outside a read the port carries a changing pattern, so a stale sample shows up
	assign dm_rdata = dm_re ? mem[dm_addr] : junk;

	always @(posedge clock) begin
		junk <= ~junk + 8'h3D;
		if (dm_we) begin
			mem[dm_addr] <= dm_wdata;
		end
	end
endmodule // pcsia_dmem_model

/* sim/tb_top.sv */
// Self-checking bench for the program-flow block.
// Assumes pcsia_map.svh on the include path and the data memory model beside it.
`timescale 1ns/1ps
`include "pcsia_map.svh"

module tb_top;
	import pcsia_pkg::*;

	logic clock;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic rst_by_power_on = 1'b1;
	logic rst_by_brownout = 1'b0;
	logic brownout_enable_fuse = 1'b1;
	logic external_resistor_mode = 1'b1;
	logic osc_speed_select, osc_use_resistor;
	logic pc_step = 1'b0, op_call = 1'b0, op_jump = 1'b0, op_return = 1'b0;
	logic op_return_with_literal = 1'b0, op_return_from_interrupt = 1'b0, irq_branch = 1'b0;
	logic [10:0] jump_operand = 11'h000;
	pcsia_pc_t fetch_pc;
	logic fetch_discard;
	logic [8:0] reg_addr = 9'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	pcsia_byte_t reg_rdata;
	pcsia_addr_t dm_addr;
	pcsia_byte_t dm_wdata;
	logic dm_we, dm_re;
	logic [7:0] dm_rdata;
	int num_errors = 0;
	int cmp_count = 0;
	logic [7:0] exp_q [$];
	logic rd_seen = 1'b0;
	pcsia_pc_t cur;
	pcsia_pc_t stk [8];
	logic [2:0] sp;
	logic [4:0] latch;
	logic [7:0] ptr, d;

	pcsia_core i_pcsia_core (.clock, .srst, .clk_en, .rst_by_power_on, .rst_by_brownout,
		.brownout_enable_fuse, .external_resistor_mode, .osc_speed_select, .osc_use_resistor,
		.pc_step, .op_call, .op_jump, .op_return, .op_return_with_literal,
		.op_return_from_interrupt, .irq_branch, .jump_operand, .fetch_pc, .fetch_discard,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dm_addr, .dm_wdata, .dm_we,
		.dm_re, .dm_rdata);

	pcsia_dmem_model i_pcsia_dmem_model (.clock, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ****************************************************************
	// Checking and reporting
	// ****************************************************************
	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Read data stands only in the cycle after the strobe, so it is sampled at that edge
	always @(posedge clock) begin
		if (rd_seen) begin
			check(reg_rdata, exp_q.pop_front());
		end
		rd_seen <= reg_rd;
	end

	// ****************************************************************
	// Drivers
	// ****************************************************************
	task automatic do_reset(input logic por, input logic bor, input logic fuse);
		@(posedge clock);
		srst <= 1'b1;
		rst_by_power_on <= por;
		rst_by_brownout <= bor;
		brownout_enable_fuse <= fuse;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		rst_by_power_on <= 1'b0;
		rst_by_brownout <= 1'b0;
		cur = 13'h0000;
		sp = 3'd0;
		#1;
		check(fetch_pc, 13'h0000);
	endtask

	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask

	// Kinds: 0 call, 1 jump, 2..4 the three returns, 5 interrupt, other step
	task automatic flow(input int k, input logic [10:0] op);
		@(posedge clock);
		case (k)
			0: op_call <= 1'b1;
			1: op_jump <= 1'b1;
			2: op_return <= 1'b1;
			3: op_return_with_literal <= 1'b1;
			4: op_return_from_interrupt <= 1'b1;
			5: irq_branch <= 1'b1;
			default: pc_step <= 1'b1;
		endcase
		jump_operand <= op;
		if (k == 0 || k == 5) begin
			stk[sp] = cur;
			sp = sp + 3'd1;
		end
		if (k >= 2 && k <= 4) begin
			sp = sp - 3'd1;
			cur = stk[sp];
		end else if (k <= 1) begin
			cur = {latch[4:3], op};
		end else if (k == 5) begin
			cur = `PCSIA_IRQ_VECTOR;
		end else begin
			cur = cur + 13'd1;
		end
		@(posedge clock);
		{op_call, op_jump, op_return, op_return_with_literal} <= 4'b0000;
		{op_return_from_interrupt, irq_branch, pc_step} <= 3'b000;
		#1;
		check(fetch_pc, cur);
		check(fetch_discard, k != 6);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		void'($urandom(49003));
		do_reset(1'b1, 1'b0, 1'b1);
		rd(9'h00C, 8'h08);
		wr(9'h00C, 8'hFF);
		rd(9'h00C, 8'h0B);
		wr(9'h00C, 8'h03);
		#1;
		check(osc_speed_select, 1'b0);
		check(osc_use_resistor, 1'b0);
		wr(9'h08C, 8'h0B);
		#1;
		check(osc_use_resistor, 1'b1);
		// Outside resistor mode the speed bit alone never hands over the rate
		@(posedge clock);
		external_resistor_mode <= 1'b0;
		#1;
		check(osc_use_resistor, 1'b0);
		do_reset(1'b0, 1'b0, 1'b1);
		rd(9'h00C, 8'h0B);
		do_reset(1'b0, 1'b1, 1'b1);
		rd(9'h00C, 8'h0A);
		wr(9'h00C, 8'h03);
		do_reset(1'b0, 1'b1, 1'b0);
		rd(9'h00C, 8'h0B);
		// Low byte write pulls the whole latch into the upper bits
		wr(9'h00A, 8'hFF);
		latch = 5'h1F;
		rd(9'h00A, 8'h1F);
		d = 8'($urandom);
		wr(9'h002, d);
		cur = {latch, d};
		#1;
		check(fetch_pc, cur);
		rd(9'h002, d);
		// Ten calls wrap the eight-deep stack, then nine pops walk it round
		wr(9'h00A, 8'h18);
		latch = 5'h18;
		for (int i = 0; i < 10; i++) begin
			flow(0, 11'($urandom));
		end
		rd(9'h00A, 8'h18);
		for (int i = 0; i < 9; i++) begin
			flow(2 + i % 3, 11'h000);
		end
		flow(5, 11'h000);
		flow(6, 11'h000);
		flow(1, 11'($urandom));
		flow(4, 11'h000);
		// A return right behind a call hands the caller's address back
		@(posedge clock);
		op_call <= 1'b1;
		jump_operand <= 11'($urandom);
		@(posedge clock);
		op_call <= 1'b0;
		op_return <= 1'b1;
		@(posedge clock);
		op_return <= 1'b0;
		#1;
		check(fetch_pc, cur);
		check(fetch_discard, 1'b1);
		// Clock enable low holds the counter despite a step request
		@(posedge clock);
		clk_en <= 1'b0;
		pc_step <= 1'b1;
		repeat (2) @(posedge clock);
		clk_en <= 1'b1;
		pc_step <= 1'b0;
		#1;
		check(fetch_pc, cur);
		// Indirect access through pointer and bank bit
		ptr = 8'h20 + 8'($urandom_range(95));
		d = 8'($urandom);
		wr(9'h004, ptr);
		wr(9'h003, 8'hFF);
		rd(9'h083, 8'h80);
		wr(9'h000, d);
		rd(9'h000, d);
		rd({1'b1, ptr}, d);
		rd({1'b0, ptr}, 8'h00);
		wr(9'h003, 8'h00);
		wr(9'h004, 8'h80);
		rd(9'h000, 8'h00);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= 9'h000;
		reg_wdata <= d;
		#1;
		check(dm_we, 1'b0);
		@(posedge clock);
		reg_wr <= 1'b0;
		repeat (3) @(posedge clock);
		summarize();
	end

	initial begin
		repeat (4000) @(posedge clock);
		num_errors++;
		summarize();
	end
endmodule // tb_top
